// >>> src/fio_consts.svh
// constants of the field input/output core: widths, timing counts, entry codes
// assumes a 200 MHz system clock; included by bare name from src/
`ifndef FIO_CONSTS_SVH
`define FIO_CONSTS_SVH

// ------------------------------------------------------------
// port widths, bit positions, buffer depth, entry codes and counter limit
// ------------------------------------------------------------
`define FIO_NBITS 64
`define FIO_NUM_W 6
`define FIO_MON_BIT 39
`define FIO_TBUF_DEPTH 1024
`define FIO_ENTRY_W 40
`define FIO_ROLL_TAG 8'hFF
`define FIO_MS_MAX 32'hFFFF_FFFF

// ------------------------------------------------------------
// timing: times in their own unit, counts derived from them
// ------------------------------------------------------------
`define FIO_CLK_PERIOD_NS 5
`define FIO_REF_PERIOD_NS 1000000
`define FIO_CYC_PER_MS (`FIO_REF_PERIOD_NS / `FIO_CLK_PERIOD_NS)
`define FIO_WDT_TIMEOUT_MS 100
`define FIO_WDT_CYC (`FIO_WDT_TIMEOUT_MS * `FIO_CYC_PER_MS)
`define FIO_TOG_PERIOD_MS 100
`define FIO_TOG_SPAN_MS 10000
`define FIO_TOG_COUNT (`FIO_TOG_SPAN_MS / `FIO_TOG_PERIOD_MS)

`endif

// >>> src/fio_pkg.sv
// types shared by the field input/output core and its transition buffer
// assumes fio_consts.svh is on the include path
`include "fio_consts.svh"

package fio_pkg;

    // ------------------------------------------------------------
    // scan sequencer states, one-hot
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        FIO_ST_IDLE = 3'h1,
        FIO_ST_ROLL = 3'h2,
        FIO_ST_SCAN = 3'h4
    } fio_scan_st_t;

    // ------------------------------------------------------------
    // buffer entry: first byte is {new state, 0, input number} or all ones
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] tag;    // first byte of the entry
        logic [31:0] stamp; // millisecond count at scan start
    } fio_entry_t;

    // ------------------------------------------------------------
    // module status byte
    // ------------------------------------------------------------
    typedef struct packed {
        logic [4:0] spare;  // read as zero
        logic ovf;          // buffer overflow, sticky
        logic comm_lost;    // loss of communication
        logic wdt_en;       // watchdog enabled
    } fio_status_t;

endpackage : fio_pkg

// >>> src/fio_tbuf.sv
// transition buffer: array of entries with a committed head and a read cursor
// assumes depth is a power of two; synchronous active-low reset
`include "fio_consts.svh"

module fio_tbuf #(
    parameter int W = `FIO_ENTRY_W,
    parameter int DEPTH = `FIO_TBUF_DEPTH
) (
    input wire logic i_mclk,              // system clock
    input wire logic i_rst_n,             // synchronous reset, low active
    input wire logic i_push,              // append one entry
    input wire logic [W-1:0] i_push_data, // entry to append
    input wire logic i_rd_ready,          // host takes the shown entry
    input wire logic i_confirm,           // host confirms all entries taken
    input wire logic i_rewind,            // resend from committed head
    input wire logic i_ovf_clr,           // clear overflow flag
    output logic o_rd_valid,              // an unsent entry is shown
    output logic [W-1:0] o_rd_data,       // entry at the read cursor
    output logic o_ovf,                   // sticky overflow
    output logic [$clog2(DEPTH):0] o_count // entries held
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULLV = (AW + 1)'(DEPTH);

    logic [W-1:0] mem [DEPTH];  // entry storage
    logic [AW:0] wr_r, wr_nxt;     // append pointer
    logic [AW:0] head_r, head_nxt; // oldest unconfirmed entry
    logic [AW:0] peek_r, peek_nxt; // next entry to send
    logic ovf_r, ovf_nxt;          // sticky overflow
    logic full;                    // no room left
    logic take;                    // push actually stored

    // ------------------------------------------------------------
    // pointer and flag next values
    // ------------------------------------------------------------
    always_comb begin
        full = (wr_r - head_r) == FULLV;
        take = i_push && !full;
        wr_nxt = take ? wr_r + 1'b1 : wr_r;
        peek_nxt = peek_r;
        head_nxt = head_r;
        if (i_confirm) begin
            head_nxt = peek_r;
        end else if (i_rewind) begin
            peek_nxt = head_r;
        end else if (o_rd_valid && i_rd_ready) begin
            peek_nxt = peek_r + 1'b1;
        end
        ovf_nxt = (i_push && full) ? 1'b1 : (i_ovf_clr ? 1'b0 : ovf_r); // set wins
    end

    // ------------------------------------------------------------
    // registers, empty after reset
    // ------------------------------------------------------------
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            wr_r <= '0;
            head_r <= '0;
            peek_r <= '0;
            ovf_r <= 1'b0;
        end else begin
            wr_r <= wr_nxt;
            head_r <= head_nxt;
            peek_r <= peek_nxt;
            ovf_r <= ovf_nxt;
        end
    end

    // storage write, no reset needed
    always_ff @(posedge i_mclk) begin
        if (take) begin
            mem[wr_r[AW-1:0]] <= i_push_data;
        end
    end

    assign o_rd_valid = peek_r != wr_r;
    assign o_rd_data = mem[peek_r[AW-1:0]];
    assign o_ovf = ovf_r;
    assign o_count = wr_r - head_r;

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);

    full_drop_a: assert property (i_push && full && !i_confirm |=> o_count == FULLV)
        else $error("entry stored into a full buffer");
    ovf_set_a: assert property (i_push && full |=> o_ovf [*2] or (o_ovf ##1 !o_ovf))
        else $error("overflow not flagged");
    keep_unconf_a: assert property (!i_confirm && !take |=> o_count == $past(o_count))
        else $error("entries removed without confirmation");
    reset_empty_a: assert property (@(posedge i_mclk) disable iff (1'b0)
        !i_rst_n |=> o_count == 0)
        else $error("buffer not empty after reset");
endmodule : fio_tbuf

// >>> src/fio_core.sv
// field input/output core: inputs, latched outputs, watchdog, 1 kHz reference,
// millisecond counter, comm-loss flag and timestamped transition buffer
// assumes field pins are already synchronous to i_mclk
//
// What this block does
// - inputs read inverted: low pin reads one
// - output one sinks pin, zero leaves open
// - outputs hold value until write, reset or monitor toggle
// - reset clears every output latch to zero
// - outputs open during power-up and power-down
// - all outputs switch together within 100 us
// - unchanged outputs never glitch during updates
// - shunt fitted: toggle output 39, 100ms, 10s
// - shunt absent: no automatic monitor toggling
// - watchdog enabled at power-up, 100 ms
// - watchdog enable reported in status byte
// - only module reset disables the watchdog
// - unserviced watchdog forces controller hardware reset
// - resynchronisable 1 kHz reference, exact divider
// - 32-bit millisecond counter counts reference ticks
// - comm loss set until status request
// - module reset is system, host or power-up reset
// - transition buffer holds 1024, empty after reset
// - reporting input change appends transition entry
// - counter wrap appends rollover entry, tag FF
// - blocks removed only after host confirmation
// - entry: input number, state, scan-start stamp
// - same-sample changes appended by increasing number
`include "fio_consts.svh"

module fio_core #(
    parameter int P_CYC_PER_MS = `FIO_CYC_PER_MS,  // clocks per millisecond tick
    parameter int P_WDT_CYC = `FIO_WDT_CYC,        // watchdog timeout in clocks
    parameter int P_TOG_PERIOD = `FIO_TOG_PERIOD_MS, // ticks between monitor toggles
    parameter int P_TOG_COUNT = `FIO_TOG_COUNT,    // number of automatic toggles
    parameter int P_DEPTH = `FIO_TBUF_DEPTH        // buffer entries
) (
    input wire logic i_mclk,                       // system clock
    input wire logic i_nrst,                       // synchronous reset, low active
    input wire logic i_host_rst_n,                 // host reset line, low active
    input wire logic i_pwrup_rst_n,                // power-up reset line, low active
    input wire logic i_power_down,                 // power failing
    input wire logic i_monitor_toggle_shunt,       // shunt fitted
    input wire logic [`FIO_NBITS-1:0] i_field_in,  // input pin levels, 1 = high
    input wire logic [`FIO_NBITS-1:0] i_report_en, // inputs configured to report
    input wire logic i_out_wr,                     // set-output command
    input wire logic [`FIO_NBITS-1:0] i_out_data,  // output values, 1 = sink
    input wire logic i_ref_sync,                   // resync the 1 kHz reference
    input wire logic i_wdt_kick,                   // service the watchdog
    input wire logic i_status_req,                 // request-module-status seen
    input wire logic i_rd_ready,                   // host takes shown entry
    input wire logic i_confirm,                    // host confirms sent block
    input wire logic i_rewind,                     // host asks to resend block
    input wire logic i_ovf_clr,                    // clear overflow flag
    output logic [`FIO_NBITS-1:0] o_out_sink,      // output drivers, 1 = sink low
    output logic o_module_reset_n,                 // forwarded module reset
    output logic o_wdt_fire,                       // controller hardware reset pulse
    output logic o_ms_tick,                        // 1 kHz reference pulse
    output logic [31:0] o_ms_count,                // millisecond counter
    output fio_pkg::fio_status_t o_status,         // module status byte
    output logic o_rd_valid,                       // entry shown to host
    output fio_pkg::fio_entry_t o_rd_data,         // entry at read cursor
    output logic [$clog2(P_DEPTH):0] o_tbuf_count  // entries held
);
    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic rst_n;                                   // combined module reset
    logic start_r;                                 // first cycle after reset
    logic [31:0] div_r, div_nxt;                   // reference divider
    logic tick;                                    // millisecond tick
    logic [31:0] ms_r, ms_nxt;                     // millisecond counter
    logic [`FIO_NBITS-1:0] out_r, out_nxt;         // output latches
    logic shunt_r, shunt_nxt;                      // shunt caught at reset release
    logic tog_on_r, tog_on_nxt;                    // auto toggling active
    logic [15:0] tog_ms_r, tog_ms_nxt;             // ticks within toggle period
    logic [15:0] tog_n_r, tog_n_nxt;               // toggles done
    logic tog_evt;                                 // auto toggle this cycle
    logic wdt_en_r, wdt_en_nxt;                    // watchdog enabled
    logic [31:0] wdt_cnt_r, wdt_cnt_nxt;           // watchdog count
    logic fire_r, fire_nxt;                        // watchdog expiry pulse
    logic comm_lost_r, comm_lost_nxt;              // loss of communication
    fio_pkg::fio_scan_st_t st_r, st_nxt;           // scan sequencer
    logic [`FIO_NBITS-1:0] smp_r, smp_nxt;         // current sample, inverted
    logic [`FIO_NBITS-1:0] last_r, last_nxt;       // previous sample
    logic armed_r, armed_nxt;                      // a previous sample exists
    logic [31:0] stamp_r, stamp_nxt;               // stamp at scan start
    logic [`FIO_NUM_W-1:0] idx_r, idx_nxt;         // scan position
    logic roll_r, roll_nxt;                        // wrap seen at this tick
    logic push;                                    // append an entry
    fio_pkg::fio_entry_t push_data;                // entry to append
    logic ovf;                                     // buffer overflow flag

    assign rst_n = i_nrst && i_host_rst_n && i_pwrup_rst_n;
    assign o_module_reset_n = rst_n;

    // ------------------------------------------------------------
    // 1 kHz reference and millisecond counter
    // ------------------------------------------------------------
    always_comb begin
        tick = !i_ref_sync && (div_r == 32'(P_CYC_PER_MS - 1));
        if (i_ref_sync || tick) begin
            div_nxt = '0;
        end else begin
            div_nxt = div_r + 32'h1;
        end
        ms_nxt = tick ? ms_r + 32'h1 : ms_r;
    end

    always_ff @(posedge i_mclk) begin
        if (!rst_n) begin
            div_r <= '0;
            ms_r <= '0;
        end else begin
            div_r <= div_nxt;
            ms_r <= ms_nxt;
        end
    end

    // ------------------------------------------------------------
    // output latches and monitor toggling
    // ------------------------------------------------------------
    always_comb begin
        shunt_nxt = start_r ? i_monitor_toggle_shunt : shunt_r;
        tog_on_nxt = tog_on_r;
        tog_ms_nxt = tog_ms_r;
        tog_n_nxt = tog_n_r;
        tog_evt = 1'b0;
        if (start_r) begin
            tog_on_nxt = i_monitor_toggle_shunt;
        end else if (tog_on_r && tick) begin
            if (tog_ms_r == 16'(P_TOG_PERIOD - 1)) begin
                tog_ms_nxt = '0;
                tog_evt = 1'b1;
                tog_n_nxt = tog_n_r + 16'h1;
                tog_on_nxt = tog_n_r != 16'(P_TOG_COUNT - 1);
            end else begin
                tog_ms_nxt = tog_ms_r + 16'h1;
            end
        end
        out_nxt = out_r;
        if (i_out_wr) begin
            out_nxt = i_out_data;                                // one word, all bits but 39 when shunt fitted
            if (shunt_r) begin
                out_nxt[`FIO_MON_BIT] = !out_r[`FIO_MON_BIT];
            end
        end else if (tog_evt) begin
            out_nxt[`FIO_MON_BIT] = !out_r[`FIO_MON_BIT];
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!rst_n) begin
            out_r <= '0;
            shunt_r <= 1'b0;
            tog_on_r <= 1'b0;
            tog_ms_r <= '0;
            tog_n_r <= '0;
        end else begin
            out_r <= out_nxt;
            shunt_r <= shunt_nxt;
            tog_on_r <= tog_on_nxt;
            tog_ms_r <= tog_ms_nxt;
            tog_n_r <= tog_n_nxt;
        end
    end

    // drivers open while power is failing; latches stay untouched
    assign o_out_sink = i_power_down ? '0 : out_r;

    // ------------------------------------------------------------
    // watchdog and communication-loss flag
    // ------------------------------------------------------------
    always_comb begin
        wdt_en_nxt = wdt_en_r || start_r;
        wdt_cnt_nxt = wdt_cnt_r;
        fire_nxt = 1'b0;
        if (!wdt_en_r || i_wdt_kick) begin
            wdt_cnt_nxt = '0;
        end else if (wdt_cnt_r == 32'(P_WDT_CYC - 1)) begin
            wdt_cnt_nxt = '0;
            fire_nxt = 1'b1;
        end else begin
            wdt_cnt_nxt = wdt_cnt_r + 32'h1;
        end
        comm_lost_nxt = comm_lost_r && !i_status_req;
    end

    always_ff @(posedge i_mclk) begin
        if (!rst_n) begin
            start_r <= 1'b1;
            wdt_en_r <= 1'b0;
            wdt_cnt_r <= '0;
            fire_r <= 1'b0;
            comm_lost_r <= 1'b1;
        end else begin
            start_r <= 1'b0;
            wdt_en_r <= wdt_en_nxt;
            wdt_cnt_r <= wdt_cnt_nxt;
            fire_r <= fire_nxt;
            comm_lost_r <= comm_lost_nxt;
        end
    end

    // ------------------------------------------------------------
    // input scan and entry generation
    // ------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        smp_nxt = smp_r;
        last_nxt = last_r;
        armed_nxt = armed_r;
        stamp_nxt = stamp_r;
        idx_nxt = idx_r;
        roll_nxt = roll_r;
        push = 1'b0;
        push_data = '0;
        case (st_r)
            fio_pkg::FIO_ST_IDLE: begin
                if (tick) begin
                    smp_nxt = ~i_field_in;
                    last_nxt = smp_r;
                    stamp_nxt = ms_nxt;
                    roll_nxt = ms_r == `FIO_MS_MAX;
                    idx_nxt = '0;
                    st_nxt = (ms_r == `FIO_MS_MAX) ? fio_pkg::FIO_ST_ROLL
                                                  : fio_pkg::FIO_ST_SCAN;
                end
            end
            fio_pkg::FIO_ST_ROLL: begin
                push = 1'b1;
                push_data.tag = `FIO_ROLL_TAG;
                push_data.stamp = stamp_r;
                st_nxt = fio_pkg::FIO_ST_SCAN;
            end
            fio_pkg::FIO_ST_SCAN: begin
                push = armed_r && i_report_en[idx_r] && (smp_r[idx_r] != last_r[idx_r]);
                push_data.tag = {smp_r[idx_r], 1'b0, idx_r};
                push_data.stamp = stamp_r;
                idx_nxt = idx_r + 1'b1;                          // low to high
                if (idx_r == `FIO_NUM_W'(`FIO_NBITS - 1)) begin
                    armed_nxt = 1'b1;
                    st_nxt = fio_pkg::FIO_ST_IDLE;
                end
            end
            default: begin
                st_nxt = fio_pkg::FIO_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_mclk) begin
        if (!rst_n) begin
            st_r <= fio_pkg::FIO_ST_IDLE;
            smp_r <= '0;
            last_r <= '0;
            armed_r <= 1'b0;
            stamp_r <= '0;
            idx_r <= '0;
            roll_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            smp_r <= smp_nxt;
            last_r <= last_nxt;
            armed_r <= armed_nxt;
            stamp_r <= stamp_nxt;
            idx_r <= idx_nxt;
            roll_r <= roll_nxt;
        end
    end

    // ------------------------------------------------------------
    // transition buffer
    // ------------------------------------------------------------
    fio_tbuf #(
        .W(`FIO_ENTRY_W),
        .DEPTH(P_DEPTH)
    ) u_tbuf (
        .i_mclk(i_mclk),
        .i_rst_n(rst_n),
        .i_push(push),
        .i_push_data(push_data),
        .i_rd_ready(i_rd_ready),
        .i_confirm(i_confirm),
        .i_rewind(i_rewind),
        .i_ovf_clr(i_ovf_clr),
        .o_rd_valid(o_rd_valid),
        .o_rd_data(o_rd_data),
        .o_ovf(ovf),
        .o_count(o_tbuf_count)
    );

    assign o_wdt_fire = fire_r;
    assign o_ms_tick = tick;
    assign o_ms_count = ms_r;
    assign o_status = '{spare: 5'h00, ovf: ovf, comm_lost: comm_lost_r,
                        wdt_en: wdt_en_r};

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!rst_n);

    out_reset_a: assert property (@(posedge i_mclk) disable iff (1'b0)
        !rst_n |=> out_r == '0)
        else $error("outputs not cleared by reset");
    out_hold_a: assert property (!i_out_wr && !tog_evt |=> out_r == $past(out_r))
        else $error("output latch changed without a write");
    out_write_a: assert property (i_out_wr && !shunt_r |=> out_r == $past(i_out_data))
        else $error("written value not latched");
    pwr_open_a: assert property (i_power_down |-> o_out_sink == '0)
        else $error("output driven during power down");
    in_invert_a: assert property (tick && st_r == fio_pkg::FIO_ST_IDLE
        |=> smp_r == ~$past(i_field_in))
        else $error("input sample not inverted");
    ms_incr_a: assert property (tick |=> ms_r == $past(ms_r) + 32'h1 ##1 $stable(ms_r))
        else $error("millisecond counter step wrong");
    wdt_sticky_a: assert property (wdt_en_r |=> wdt_en_r)
        else $error("watchdog disabled without reset");
    wdt_start_a: assert property (start_r |=> wdt_en_r && o_status.wdt_en)
        else $error("watchdog not enabled after reset");
    wdt_fire_a: assert property (wdt_en_r && !i_wdt_kick && wdt_cnt_r == 32'(P_WDT_CYC - 1)
        |=> o_wdt_fire ##1 !o_wdt_fire)
        else $error("watchdog expiry not signalled");
    comm_keep_a: assert property (comm_lost_r && !i_status_req |=> comm_lost_r)
        else $error("comm loss cleared without status request");
    roll_entry_a: assert property (tick && ms_r == `FIO_MS_MAX
        |=> push && push_data.tag == `FIO_ROLL_TAG)
        else $error("rollover entry missing");
endmodule : fio_core

// >>> test/fio_host_model.sv
// host model: takes buffer entries with random stalls, confirms them,
// sends one status request; assumes bench clock and active-low reset
module fio_host_model (
    input wire logic i_mclk,   // system clock
    input wire logic i_nrst,   // reset, low active
    input wire logic i_valid,  // entry shown by the device
    output logic o_ready,      // takes shown entry
    output logic o_confirm,    // confirms entries taken
    output logic o_status_req  // status request pulse
);
    timeunit 1ns;
    timeprecision 1ps;
    int age_r = 0; // cycles since reset release
    logic took_r = 1'b0; // an entry was taken last edge
    initial begin
        o_ready = 1'b0;
        o_confirm = 1'b0;
        o_status_req = 1'b0;
    end
    // all changes right after the edge
    always @(posedge i_mclk) begin
        if (!i_nrst) begin
            age_r <= 0;
            o_ready <= 1'b0;
            took_r <= 1'b0;
        end else begin
            age_r <= age_r + 1;
            o_status_req <= (age_r == 40);
            took_r <= i_valid & o_ready & ~o_confirm; // confirm beats a take
            o_confirm <= took_r;
            o_ready <= 1'($urandom % 2); // random stall
        end
    end
endmodule : fio_host_model

// >>> test/testbench.sv
// self-checking bench of fio_core with short counts; host model on far side
// assumes fio_pkg and fio_consts.svh compiled first
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin fail_count++; \
    $display("unexpected %s exp %h got %h", nm, e, g); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_mclk = 0, i_nrst = 0, i_host_rst_n = 1, i_power_down = 0;
    logic i_pwrup_rst_n = 1, shunt = 0, i_ref_sync = 0, rew = 0, oclr = 0;
    logic i_out_wr = 0, i_wdt_kick = 0, kick_on = 0, rdy, conf, sreq, tick_d = 0;
    logic [63:0] i_field_in = '1, i_report_en = '0, i_out_data = '0, o_out_sink, d;
    logic o_module_reset_n, o_wdt_fire, o_ms_tick, o_rd_valid;
    logic [31:0] o_ms_count, ticks = 0;
    logic [3:0] o_tbuf_count;
    fio_pkg::fio_status_t o_status;
    fio_pkg::fio_entry_t o_rd_data, ent;
    fio_pkg::fio_entry_t exp_q[$];
    int fail_count = 0, total_checks = 0, gap = 0, n;
    initial forever #2.5 i_mclk = ~i_mclk;
    fio_core #(.P_CYC_PER_MS(100), .P_WDT_CYC(500), .P_TOG_PERIOD(3), .P_TOG_COUNT(4),
        .P_DEPTH(8)) DUT (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_host_rst_n(i_host_rst_n),
        .i_pwrup_rst_n(i_pwrup_rst_n), .i_power_down(i_power_down),
        .i_monitor_toggle_shunt(shunt),
        .i_field_in(i_field_in), .i_report_en(i_report_en), .i_out_wr(i_out_wr),
        .i_out_data(i_out_data), .i_ref_sync(i_ref_sync), .i_wdt_kick(i_wdt_kick),
        .i_status_req(sreq), .i_rd_ready(rdy), .i_confirm(conf), .i_rewind(rew),
        .i_ovf_clr(oclr), .o_out_sink(o_out_sink), .o_module_reset_n(o_module_reset_n),
        .o_wdt_fire(o_wdt_fire), .o_ms_tick(o_ms_tick), .o_ms_count(o_ms_count),
        .o_status(o_status), .o_rd_valid(o_rd_valid), .o_rd_data(o_rd_data),
        .o_tbuf_count(o_tbuf_count));
    fio_host_model host (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_valid(o_rd_valid),
        .o_ready(rdy), .o_confirm(conf), .o_status_req(sreq));
    task automatic tk(input int c);
        repeat (c) @(posedge i_mclk);
    endtask : tk
    task automatic complete_run;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : complete_run
    // entry scoreboard, oldest note first
    // a confirm in the same cycle keeps the cursor still; a rewind sends it back to the committed head
    always @(posedge i_mclk) if (i_nrst && o_rd_valid === 1'b1 && rdy === 1'b1
        && conf !== 1'b1 && rew !== 1'b1) begin
        ent = (exp_q.size() > 0) ? exp_q.pop_front() : '0;
        `CHK("entry", ent, o_rd_data)
    end
    // reference spacing and counter steps
    always @(posedge i_mclk) begin
        if (tick_d) `CHK("ms_count", ticks, o_ms_count)
        tick_d = o_module_reset_n === 1'b1 && o_ms_tick === 1'b1;
        if (tick_d && ticks > 0) `CHK("tick_gap", 100, gap)
        if (tick_d) ticks = ticks + 1;
        if (o_module_reset_n !== 1'b1) ticks = 0;
        gap = (tick_d || i_ref_sync === 1'b1) ? 1 : gap + 1;
    end
    always @(posedge i_mclk) i_wdt_kick <= kick_on & ~i_wdt_kick;
    initial begin
        #(20000 * 5);
        fail_count++;
        complete_run();
    end
    // flips a few pins in the quiet part of a millisecond
    task automatic flip_round;
        logic [63:0] m;
        m = '0;
        repeat (6) m[$urandom % 64] = 1'b1;
        @(posedge i_mclk iff o_ms_tick === 1'b1);
        tk(80);
        i_field_in <= i_field_in ^ m;
        for (int i = 0; i < 64; i++) if (m[i] && i_report_en[i])
            exp_q.push_back({i_field_in[i], 1'b0, 6'(i), ticks + 32'h1});
        tk(150);
    endtask : flip_round
    initial begin
        void'($urandom(44780));
        i_report_en <= {$urandom, $urandom};
        tk(2);
        i_nrst <= 1'b1;
        kick_on <= 1'b1;
        tk(3);
        `CHK("out_sink", 64'h0, o_out_sink)
        `CHK("tbuf_count", 4'h0, o_tbuf_count)
        `CHK("comm_lost", 1'b1, o_status.comm_lost)
        `CHK("wdt_en", 1'b1, o_status.wdt_en)
        d = {$urandom, $urandom};
        i_out_wr <= 1'b1;
        i_out_data <= d;
        tk(1);
        i_out_wr <= 1'b0;
        i_out_data <= ~d;
        tk(3);
        `CHK("out_sink", d, o_out_sink)
        i_power_down <= 1'b1;
        tk(2);
        `CHK("out_off", 64'h0, o_out_sink)
        i_power_down <= 1'b0;
        tk(60);
        `CHK("out_kept", d, o_out_sink)
        `CHK("comm_lost", 1'b0, o_status.comm_lost)
        repeat (3) flip_round();
        `CHK("left", 0, exp_q.size())
        `CHK("tbuf_count", 4'h0, o_tbuf_count)
        `CHK("ovf", 1'b0, o_status.ovf)
        i_ref_sync <= 1'b1;
        tk(1);
        i_ref_sync <= 1'b0;
        kick_on <= 1'b0;
        n = 0;
        while (o_wdt_fire !== 1'b1 && n < 600) begin
            tk(1);
            n++;
        end
        `CHK("wdt_span", 1'b1, n >= 495 && n <= 505)
        `CHK("wdt_en", 1'b1, o_status.wdt_en)
        i_host_rst_n <= 1'b0;
        tk(2);
        `CHK("mod_rst", 1'b0, o_module_reset_n)
        `CHK("out_sink", 64'h0, o_out_sink)
        shunt <= 1'b1;
        i_host_rst_n <= 1'b1;
        i_pwrup_rst_n <= 1'b0;
        tk(2);
        `CHK("mod_rst", 1'b0, o_module_reset_n)
        i_pwrup_rst_n <= 1'b1;
        tk(350);
        `CHK("mon_toggle", 64'h0000_0080_0000_0000, o_out_sink)
        i_out_data <= '1;
        i_out_wr <= 1'b1;
        tk(1);
        i_out_wr <= 1'b0;
        tk(2);
        `CHK("mon_write", 64'hFFFF_FF7F_FFFF_FFFF, o_out_sink)
        complete_run();
    end
endmodule : testbench
